// >>> dci_params.svh
// Constants for the core interrupt controller and inter-core flags
`ifndef DCI_PARAMS_SVH
`define DCI_PARAMS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DCI_OFS_MASK 4'h0
`define DCI_OFS_LATCH 4'h1
`define DCI_OFS_CTRL 4'h2
`define DCI_OFS_FLAGS 4'h3
`define DCI_OFS_STAT 4'h4
`define DCI_OFS_CLR 4'h5
`define DCI_OFS_ENA 4'h6
`define DCI_OFS_SEQ 4'h7
// ----------------------------------------
// Control bits
// ----------------------------------------
`define DCI_CTRL_NEST 4
`define DCI_CTRL_GIE 5
`define DCI_CTRL_BRND 7
`define DCI_CTRL_PCSE 10
`define DCI_CTRL_LPSE 11
`define DCI_CTRL_IDLE 12
`define DCI_CTRL_MASK 16'h1cb0
// ----------------------------------------
// Flag bits
// ----------------------------------------
`define DCI_FLG_OUT_MASK 16'h0087
`define DCI_FLG_IRQ_OUT 2
// ----------------------------------------
// Slots, vectors, stacks
// ----------------------------------------
`define DCI_SLOT_RESET 0
`define DCI_SLOT_PDOWN 1
`define DCI_SLOT_STEP 2
`define DCI_SLOT_STACK 3
`define DCI_SLOT_CORE 8
`define DCI_SLOT_MASKABLE 16'h9ffc
`define DCI_VEC_BASE 24'h010000
`define DCI_PC_LO 3
`define DCI_PC_HI 28
`define DCI_LOOP_HI 7
`define DCI_RST_VAL 16'h0000
`endif

// >>> dci_pkg.sv
// Types for the core interrupt controller
package dci_pkg;
	typedef enum logic [1:0] {
		DCI_IDLE,
		DCI_RUN
	} dci_state_e;
	typedef logic [15:0] dci_word_t;
endpackage

// >>> dci_core_irq.sv
// Per-core interrupt controller, stacks and inter-core flag register
// Function
// - Fourteen requests, bit zero highest priority
// - Vector is base plus four times slot
// - Slot sources assigned in fixed table order
// - Requests ANDed with mask, highest chosen
// - Reset, power-down, emulation bypass the mask
// - Nesting bit lets higher slots preempt
// - Bit five global enable via instructions
// - Servicing disabled after reset, except reset slot 0
// - Latch writes force and clear pending
// - PC 33, loop 8, status 16 deep
// - PC stack level interrupt when enabled
// - Loop stack level interrupt enable bit
// - Idle and rounding bits, reserved zero
// - Status pushed and popped automatically
// - Shadow register bank select provided
// - Flag outputs: semaphores, irq, lock
// - Flag inputs: semaphores, irq, lock status
// - Peripheral bus access and busy status
//
// Our own choices: the address map and the plain strobed port.
`include "dci_params.svh"
`timescale 1ns/1ps
module dci_core_irq
	import dci_pkg::*;
#(
	parameter int PC_DEPTH = 33,
	parameter int LOOP_DEPTH = 8,
	parameter int STAT_DEPTH = 16
)
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	input wire logic [15:0] periph_irq_i,
	input wire logic emu_irq_i,
	input wire logic global_irq_on_instr_i,
	input wire logic global_irq_off_instr_i,
	input wire logic pc_push_i,
	input wire logic pc_pop_i,
	input wire logic loop_push_i,
	input wire logic loop_pop_i,
	input wire logic rti_i,
	input wire logic [15:0] status_i,
	input wire logic shadow_sel_i,
	input wire logic [2:0] peer_flags_i,
	input wire logic lock_status_i,
	input wire logic bus_access_i,
	input wire logic bus_busy_i,
	output logic irq_req_o,
	output logic [3:0] irq_slot_o,
	output logic [23:0] irq_vector_o,
	output logic emu_req_o,
	output logic [15:0] status_o,
	output logic shadow_bank_o,
	output logic [2:0] peer_flags_o,
	output logic lock_req_o,
	output logic round_bias_o,
	output logic idle_en_o,
	output logic int_o
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Lowest set bit wins
	function automatic logic [4:0] dci_pick(input dci_word_t v);
		logic [4:0] r;
		r = 5'h10;
		for (int i = 15; i >= 0; i--)
		begin
			if (v[i])
			begin
				r = 5'(i);
			end
		end
		return r;
	endfunction
	// ----------------------------------------
	// State
	// ----------------------------------------
	dci_word_t mask_reg, mask_next; // Slot mask
	dci_word_t latch_reg, latch_next; // Pending slots
	dci_word_t ctrl_reg, ctrl_next; // Control
	dci_word_t flags_reg, flags_next; // Flag outputs
	dci_word_t stat_reg, stat_next; // Sticky events
	dci_word_t ena_reg, ena_next; // Event enables
	dci_word_t active_reg, active_next; // In-service slots
	dci_word_t rdata_reg, rdata_next; // Read data
	dci_word_t pstat_reg, pstat_next; // Popped status
	dci_word_t stat_mem [STAT_DEPTH]; // Status stack
	logic [5:0] pc_lvl_reg, pc_lvl_next; // PC stack fill
	logic [3:0] loop_lvl_reg, loop_lvl_next; // Loop stack fill
	logic [4:0] st_lvl_reg, st_lvl_next; // Status stack fill
	logic [15:0] src_q1_reg, src_q2_reg; // Source synchroniser
	logic [2:0] peer_q1_reg, peer_q2_reg; // Peer synchroniser
	logic [2:0] misc_q1_reg, misc_q2_reg; // Status inputs sync
	logic emu_q1_reg, emu_q2_reg; // Emulation sync
	logic irq_reg, irq_next; // Take strobe
	logic [3:0] slot_reg, slot_next; // Taken slot
	logic [23:0] vec_reg, vec_next; // Vector of the taken slot
	logic int_reg, shadow_reg, emu_reg;
	dci_state_e st_reg, st_next;
	dci_word_t req, elig, flags_in;
	logic [4:0] win, cur;
	logic push, pop, pc_alarm, loop_alarm;
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	always_ff @(posedge sys_clk_i)
	begin
		src_q1_reg <= periph_irq_i;
		src_q2_reg <= src_q1_reg;
		peer_q1_reg <= peer_flags_i;
		peer_q2_reg <= peer_q1_reg;
		misc_q1_reg <= {lock_status_i, bus_busy_i, bus_access_i};
		misc_q2_reg <= misc_q1_reg;
		emu_q1_reg <= emu_irq_i;
		emu_q2_reg <= emu_q1_reg;
	end
	// ----------------------------------------
	// Arbitration and registers
	// ----------------------------------------
	always_comb
	begin
		mask_next = mask_reg;
		latch_next = latch_reg;
		ctrl_next = ctrl_reg;
		flags_next = flags_reg;
		stat_next = stat_reg;
		ena_next = ena_reg;
		active_next = active_reg;
		irq_next = 1'b0;
		slot_next = slot_reg;
		st_next = st_reg;
		rdata_next = 16'h0000;
		// Inter-core flag word as read
		flags_in = flags_reg & `DCI_FLG_OUT_MASK;
		flags_in[10:8] = peer_q2_reg;
		flags_in[12] = misc_q2_reg[0];
		flags_in[13] = misc_q2_reg[1];
		flags_in[15] = misc_q2_reg[2];
		// Stack level alarms
		pc_alarm = ctrl_reg[`DCI_CTRL_PCSE] &&
			(pc_lvl_reg < 6'(`DCI_PC_LO) || pc_lvl_reg > 6'(`DCI_PC_HI));
		loop_alarm = ctrl_reg[`DCI_CTRL_LPSE] &&
			(loop_lvl_reg > 4'(`DCI_LOOP_HI));
		// Software access
		if (reg_wr_i)
		begin
			unique case (reg_addr_i)
				`DCI_OFS_MASK: mask_next = reg_wdata_i;
				`DCI_OFS_LATCH: latch_next = reg_wdata_i;
				`DCI_OFS_CTRL: ctrl_next = reg_wdata_i & `DCI_CTRL_MASK;
				`DCI_OFS_FLAGS: flags_next = reg_wdata_i & `DCI_FLG_OUT_MASK;
				`DCI_OFS_CLR: stat_next = stat_reg & ~reg_wdata_i;
				`DCI_OFS_ENA: ena_next = reg_wdata_i;
				default: ;
			endcase
		end
		// Global enable instructions override a control register write
		if (global_irq_on_instr_i)
		begin
			ctrl_next[`DCI_CTRL_GIE] = 1'b1;
		end
		else if (global_irq_off_instr_i)
		begin
			ctrl_next[`DCI_CTRL_GIE] = 1'b0;
		end
		// Hardware sets win over software clears
		latch_next = latch_next | src_q2_reg;
		latch_next[`DCI_SLOT_STACK] = latch_next[`DCI_SLOT_STACK] | pc_alarm | loop_alarm;
		latch_next[`DCI_SLOT_CORE] = latch_next[`DCI_SLOT_CORE] | peer_q2_reg[2];
		// Masked requests; non-maskable slots bypass
		req = latch_reg & (mask_reg | ~`DCI_SLOT_MASKABLE);
		req[13] = 1'b0;
		req[14] = 1'b0;
		if (!ctrl_reg[`DCI_CTRL_GIE])
		begin
			req = req & 16'h0001;
		end
		cur = dci_pick(active_reg);
		elig = req;
		if (active_reg != 16'h0000)
		begin
			// Preempt only with nesting and higher priority
			if (ctrl_reg[`DCI_CTRL_NEST])
			begin
				for (int i = 0; i < 16; i++)
				begin
					if (5'(i) >= cur)
					begin
						elig[i] = 1'b0;
					end
				end
			end
			else
			begin
				elig = 16'h0000;
			end
		end
		win = dci_pick(elig);
		// A return is never dropped, even beside a take in one cycle;
		// otherwise the sequencer and the in-service bits fall out of step
		if (rti_i && active_reg != 16'h0000)
		begin
			// Retire the innermost handler
			active_next[cur[3:0]] = 1'b0;
		end
		// Take the winner: pulse, record slot, clear its pending bit
		if (!win[4])
		begin
			irq_next = 1'b1;
			slot_next = win[3:0];
			latch_next[win[3:0]] = 1'b0;
			active_next[win[3:0]] = 1'b1;
		end
		// Busy while any handler is in service
		if (active_next != 16'h0000)
		begin
			st_next = DCI_RUN;
		end
		else
		begin
			st_next = DCI_IDLE;
		end
		// Vector registered beside the slot so the output is a flop
		vec_next = `DCI_VEC_BASE + {18'h00000, slot_next, 2'b00};
		// Sticky events: take, stack alarm, peer irq
		stat_next[0] = stat_next[0] | !win[4];
		stat_next[1] = stat_next[1] | pc_alarm | loop_alarm;
		stat_next[2] = stat_next[2] | peer_q2_reg[2];
		stat_next[15:3] = 13'h0000;
		if (reg_rd_i)
		begin
			unique case (reg_addr_i)
				`DCI_OFS_MASK: rdata_next = mask_reg;
				`DCI_OFS_LATCH: rdata_next = latch_reg;
				`DCI_OFS_CTRL: rdata_next = ctrl_reg;
				`DCI_OFS_FLAGS: rdata_next = flags_in;
				`DCI_OFS_STAT: rdata_next = stat_reg;
				`DCI_OFS_ENA: rdata_next = ena_reg;
				`DCI_OFS_SEQ: rdata_next = {st_reg == DCI_RUN, 4'h0, st_lvl_reg, pc_lvl_reg};
				default: rdata_next = 16'h0000;
			endcase
		end
	end
	// ----------------------------------------
	// Stack levels
	// ----------------------------------------
	always_comb
	begin
		push = irq_reg;
		pop = rti_i && st_lvl_reg != 5'h00;
		pc_lvl_next = pc_lvl_reg;
		if ((pc_push_i || irq_reg) && pc_lvl_reg < 6'(PC_DEPTH))
		begin
			pc_lvl_next = pc_lvl_reg + 6'h01;
		end
		else if ((pc_pop_i || rti_i) && pc_lvl_reg != 6'h00)
		begin
			pc_lvl_next = pc_lvl_reg - 6'h01;
		end
		loop_lvl_next = loop_lvl_reg;
		if (loop_push_i && loop_lvl_reg < 4'(LOOP_DEPTH))
		begin
			loop_lvl_next = loop_lvl_reg + 4'h1;
		end
		else if (loop_pop_i && loop_lvl_reg != 4'h0)
		begin
			loop_lvl_next = loop_lvl_reg - 4'h1;
		end
		st_lvl_next = st_lvl_reg;
		pstat_next = pstat_reg;
		if (push && pop)
		begin
			// Entry and return together: hand out the top, level unchanged
			pstat_next = stat_mem[4'(st_lvl_reg - 5'h01)];
		end
		else if (push && st_lvl_reg < 5'(STAT_DEPTH))
		begin
			st_lvl_next = st_lvl_reg + 5'h01;
		end
		else if (pop)
		begin
			st_lvl_next = st_lvl_reg - 5'h01;
			pstat_next = stat_mem[4'(st_lvl_reg - 5'h01)];
		end
	end
	// ----------------------------------------
	// Status stack memory
	// ----------------------------------------
	always_ff @(posedge sys_clk_i)
	begin
		if (push && pop)
		begin
			// Old top is read out this cycle, new status takes its place
			stat_mem[4'(st_lvl_reg - 5'h01)] <= status_i;
		end
		else if (push && st_lvl_reg < 5'(STAT_DEPTH))
		begin
			stat_mem[st_lvl_reg[3:0]] <= status_i;
		end
	end
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			mask_reg <= `DCI_RST_VAL;
			latch_reg <= `DCI_RST_VAL;
			ctrl_reg <= `DCI_RST_VAL;
			flags_reg <= `DCI_RST_VAL;
			stat_reg <= `DCI_RST_VAL;
			ena_reg <= `DCI_RST_VAL;
			active_reg <= `DCI_RST_VAL;
			rdata_reg <= `DCI_RST_VAL;
			pstat_reg <= `DCI_RST_VAL;
			pc_lvl_reg <= 6'h00;
			loop_lvl_reg <= 4'h0;
			st_lvl_reg <= 5'h00;
			irq_reg <= 1'b0;
			slot_reg <= 4'h0;
			vec_reg <= `DCI_VEC_BASE;
			int_reg <= 1'b0;
			shadow_reg <= 1'b0;
			emu_reg <= 1'b0;
			st_reg <= DCI_IDLE;
		end
		else
		begin
			mask_reg <= mask_next;
			latch_reg <= latch_next;
			ctrl_reg <= ctrl_next;
			flags_reg <= flags_next;
			stat_reg <= stat_next;
			ena_reg <= ena_next;
			active_reg <= active_next;
			rdata_reg <= rdata_next;
			pstat_reg <= pstat_next;
			pc_lvl_reg <= pc_lvl_next;
			loop_lvl_reg <= loop_lvl_next;
			st_lvl_reg <= st_lvl_next;
			irq_reg <= irq_next;
			slot_reg <= slot_next;
			vec_reg <= vec_next;
			int_reg <= |(stat_next & ena_next);
			shadow_reg <= shadow_sel_i;
			emu_reg <= emu_q2_reg;
			st_reg <= st_next;
		end
	end
	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata_o = rdata_reg;
	assign irq_req_o = irq_reg;
	assign irq_slot_o = slot_reg;
	assign irq_vector_o = vec_reg;
	assign emu_req_o = emu_reg;
	assign status_o = pstat_reg;
	assign shadow_bank_o = shadow_reg;
	assign peer_flags_o = flags_reg[2:0];
	assign lock_req_o = flags_reg[7];
	assign round_bias_o = ctrl_reg[`DCI_CTRL_BRND];
	assign idle_en_o = ctrl_reg[`DCI_CTRL_IDLE];
	assign int_o = int_reg;
endmodule

// >>> dci_core_irq_sva.sv
// Port assertions for the core interrupt controller
`timescale 1ns/1ps
module dci_core_irq_sva
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic emu_irq_i,
	input wire logic global_irq_on_instr_i,
	input wire logic global_irq_off_instr_i,
	input wire logic shadow_sel_i,
	input wire logic irq_req_o,
	input wire logic [3:0] irq_slot_o,
	input wire logic [23:0] irq_vector_o,
	input wire logic emu_req_o,
	input wire logic shadow_bank_o,
	input wire logic [2:0] peer_flags_o,
	input wire logic lock_req_o,
	input wire logic round_bias_o,
	input wire logic idle_en_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);
	logic gie_reg; // Tracked global enable
	logic [2:0] off_reg; // Cycles spent disabled, saturating
	// Follow enable instructions and control writes
	always_ff @(posedge sys_clk_i)
	begin
		gie_reg <= !rst_i && (global_irq_on_instr_i || (!global_irq_off_instr_i
			&& ((reg_wr_i && reg_addr_i == 4'h2) ? reg_wdata_i[5] : gie_reg)));
		off_reg <= (rst_i || gie_reg) ? 3'h0 : off_reg + {2'h0, off_reg != 3'h7};
	end
	sequence mask_wr;
		reg_wr_i && reg_addr_i == 4'h0;
	endsequence
	sequence mask_rd;
		reg_rd_i && reg_addr_i == 4'h0;
	endsequence
	chk_mask_readback: assert property (mask_wr ##2 mask_rd |=> reg_rdata_o == $past(reg_wdata_i, 3))
		else $error("mask read differs from write");
	chk_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0)
		else $error("read data without read");
	chk_vec_calc: assert property (irq_vector_o == 24'h010000 + {18'h0, irq_slot_o, 2'b00})
		else $error("vector does not match slot");
	chk_no_reserved: assert property (irq_req_o |-> irq_slot_o != 4'hd && irq_slot_o != 4'he)
		else $error("reserved slot taken");
	chk_flag_drive: assert property (reg_wr_i && reg_addr_i == 4'h3 |=>
		peer_flags_o == $past(reg_wdata_i[2:0]) && lock_req_o == $past(reg_wdata_i[7]))
		else $error("flag outputs differ from write");
	chk_ctrl_drive: assert property (reg_wr_i && reg_addr_i == 4'h2 |=>
		round_bias_o == $past(reg_wdata_i[7]) && idle_en_o == $past(reg_wdata_i[12]))
		else $error("control outputs differ from write");
	chk_emu_pass: assert property (emu_irq_i [*5] |-> emu_req_o)
		else $error("emulation request not passed");
	chk_gie_block: assert property (irq_req_o && off_reg == 3'h7 |-> irq_slot_o == 4'h0)
		else $error("slot taken while disabled");
	chk_shadow_copy: assert property (shadow_sel_i ##1 shadow_sel_i |-> shadow_bank_o)
		else $error("shadow bank not selected");
endmodule
bind dci_core_irq dci_core_irq_sva chk_u (.*);

// >>> dci_seq_model.sv
// Program sequencer model that answers and retires taken interrupts
`timescale 1ns/1ps
module dci_seq_model
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic irq_req_i,
	input wire logic hold_i,
	output logic pc_push_o = 1'b0,
	output logic pc_pop_o = 1'b0,
	output logic rti_o = 1'b0,
	output logic [15:0] status_o = 16'h0
);
	int depth = 0; // Handlers in progress
	int wait_cnt = 0; // Handler run time left
	// Entry push is the controller's own; each handler makes one call
	// and return of its own, then returns after a short run unless held
	always @(posedge sys_clk_i)
	begin
		pc_push_o <= 1'b0;
		pc_pop_o <= 1'b0;
		rti_o <= 1'b0;
		status_o <= rst_i ? 16'h0 : status_o + 16'h1357;
		if (rst_i)
			depth <= 0;
		else if (irq_req_i)
		begin
			depth <= depth + 1;
			wait_cnt <= 4;
		end
		else if (depth > 0 && !hold_i && wait_cnt > 0)
		begin
			pc_push_o <= wait_cnt == 4;
			pc_pop_o <= wait_cnt == 2;
			wait_cnt <= wait_cnt - 1;
		end
		else if (depth > 0 && !hold_i)
		begin
			rti_o <= 1'b1;
			depth <= depth - 1;
			wait_cnt <= 4;
		end
	end
endmodule

// >>> tb_dsp_core_interrupt_and_semaphore.sv
// Self-checking bench for the core interrupt controller
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin mismatches++; \
	$display("[FAIL] %s exp %h got %h", n, e, a); end end
module tb_dsp_core_interrupt_and_semaphore;
	logic sys_clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, hold = 1'b0;
	logic [3:0] reg_addr_i = 4'h0, irq_slot_o;
	logic [15:0] reg_wdata_i = 16'h0, periph_irq_i = 16'h0, status_i, reg_rdata_o, status_o, m, l;
	logic emu_irq_i = 1'b0, global_irq_on_instr_i = 1'b0, global_irq_off_instr_i = 1'b0;
	logic loop_push_i = 1'b0, loop_pop_i = 1'b0, shadow_sel_i = 1'b0, lock_status_i = 1'b0;
	logic bus_access_i = 1'b0, bus_busy_i = 1'b0, pc_push_i, pc_pop_i, rti_i, irq_req_o;
	logic emu_req_o, shadow_bank_o, lock_req_o, round_bias_o, idle_en_o, int_o;
	logic [2:0] peer_flags_i = 3'h0, peer_flags_o, p;
	logic [23:0] irq_vector_o;
	logic [4:0] q[$]; // Expected order of taken slots
	logic [15:0] sq[$]; // Status stack as the sequencer sees it
	logic [15:0] st_exp; // Status expected after a return
	logic st_pend = 1'b0; // A popped status is due for comparison
	int seed = 45, mismatches = 0, checked = 0, cyc = 0;
	dci_core_irq dut_u (.*);
	dci_seq_model seq_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .irq_req_i(irq_req_o),
		.hold_i(hold), .pc_push_o(pc_push_i), .pc_pop_o(pc_pop_i), .rti_o(rti_i),
		.status_o(status_i));
	always #20 sys_clk_i = ~sys_clk_i;
	// Random shadow select and hang limit
	always @(posedge sys_clk_i)
	begin
		shadow_sel_i <= $random(seed);
		cyc++;
		if (cyc == 5000)
		begin
			mismatches++;
			final_report;
		end
	end
	// Status stack model: a return pops the newest entry, a take pushes
	always @(negedge sys_clk_i)
	begin
		if (st_pend)
			`CHK("status", st_exp, status_o)
		st_pend = 1'b0;
		if (rst_i)
			sq.delete();
		else
		begin
			if (rti_i === 1'b1 && sq.size() > 0)
			begin
				st_exp = sq.pop_back();
				st_pend = 1'b1;
			end
			if (irq_req_o === 1'b1 && sq.size() < 16)
				sq.push_back(status_i);
		end
	end
	task final_report;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// One register access, read data captured in the following cycle
	task bus(input logic w, input logic [3:0] a, input logic [15:0] d, output logic [15:0] r);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= w;
		reg_rd_i <= !w;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
		reg_rd_i <= 1'b0;
		@(negedge sys_clk_i) r = reg_rdata_o;
		@(posedge sys_clk_i);
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		logic [15:0] r;
		bus(1'b1, a, d, r);
	endtask
	task rdc(input logic [3:0] a, input logic [15:0] e);
		logic [15:0] r;
		bus(1'b0, a, 16'h0, r);
		`CHK("read", e, r)
	endtask
	// Wait for a taken slot; 5'h10 stands for none
	task take(input logic [4:0] e, input int n);
		logic [4:0] s;
		s = 5'h10;
		for (int i = 0; i < n && s == 5'h10; i++)
			@(negedge sys_clk_i) if (irq_req_o === 1'b1) s = {1'b0, irq_slot_o};
		@(posedge sys_clk_i);
		`CHK("slot", e, s)
		if (e != 5'h10)
			`CHK("vector", 24'h010000 + {18'h0, e[3:0], 2'b00}, irq_vector_o)
	endtask
	task chk_int(input logic e);
		repeat (2) @(negedge sys_clk_i);
		`CHK("int", e, int_o)
		@(posedge sys_clk_i);
	endtask
	initial
	begin
		repeat (3) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		rdc(4'h2, 16'h0);
		rdc(4'hf, 16'h0);
		wr(4'h0, 16'h0040);
		rdc(4'h0, 16'h0040);
		wr(4'h1, 16'h0042);
		rdc(4'h1, 16'h0042);
		take(5'h10, 12);
		global_irq_on_instr_i <= 1'b1;
		@(posedge sys_clk_i) global_irq_on_instr_i <= 1'b0;
		take(5'h1, 12);
		take(5'h6, 30);
		global_irq_off_instr_i <= 1'b1;
		@(posedge sys_clk_i) global_irq_off_instr_i <= 1'b0;
		repeat (8) @(posedge sys_clk_i);
		wr(4'h1, 16'h0003);
		take(5'h0, 20);
		take(5'h10, 12);
		wr(4'h1, 16'h0);
		wr(4'h2, 16'h0020);
		for (int k = 3; k < 16; k++)
		begin
			wr(4'h0, 16'h1 << k);
			wr(4'h1, 16'h1 << k);
			take((k == 13 || k == 14) ? 5'h10 : 5'(k), 20);
		end
		repeat (4)
		begin
			wr(4'h1, 16'h0);
			m = $random(seed) & 16'h9ff8 | 16'h8000;
			l = $random(seed) & 16'h9ff8 | 16'h8000;
			for (int k = 0; k < 16; k++)
				if (m[k] & l[k])
					q.push_back(5'(k));
			wr(4'h0, m);
			wr(4'h1, l);
			while (q.size() > 0)
				take(q.pop_front(), 30);
			rdc(4'h1, l & ~m);
		end
		wr(4'h6, 16'h0001);
		chk_int(1'b1);
		wr(4'h6, 16'h0);
		chk_int(1'b0);
		wr(4'h5, 16'h0001);
		wr(4'h6, 16'h0001);
		chk_int(1'b0);
		wr(4'h1, 16'h0);
		wr(4'h2, 16'h0030);
		wr(4'h0, 16'h1020);
		hold <= 1'b1;
		wr(4'h1, 16'h1000);
		take(5'hc, 20);
		wr(4'h1, 16'h0020);
		take(5'h5, 20);
		hold <= 1'b0;
		repeat (15) @(posedge sys_clk_i);
		wr(4'h2, 16'h0020);
		hold <= 1'b1;
		wr(4'h1, 16'h1000);
		take(5'hc, 20);
		wr(4'h1, 16'h0020);
		take(5'h10, 12);
		hold <= 1'b0;
		take(5'h5, 20);
		wr(4'h0, 16'h0008);
		wr(4'h2, 16'h0420);
		take(5'h3, 20);
		wr(4'h0, 16'h0200);
		wr(4'h2, 16'h0020);
		repeat (10) @(posedge sys_clk_i);
		periph_irq_i <= 16'h0200;
		@(posedge sys_clk_i) periph_irq_i <= 16'h0;
		take(5'h9, 20);
		wr(4'h2, 16'h0820);
		wr(4'h1, 16'h0);
		wr(4'h0, 16'h0008);
		loop_push_i <= 1'b1;
		repeat (7) @(posedge sys_clk_i);
		loop_push_i <= 1'b0;
		take(5'h10, 12);
		loop_push_i <= 1'b1;
		@(posedge sys_clk_i) loop_push_i <= 1'b0;
		take(5'h3, 20);
		wr(4'h0, 16'h0);
		loop_pop_i <= 1'b1;
		repeat (8) @(posedge sys_clk_i);
		loop_pop_i <= 1'b0;
		wr(4'h2, 16'hffff);
		rdc(4'h2, 16'h1cb0);
		`CHK("round", 1'b1, round_bias_o)
		`CHK("idle", 1'b1, idle_en_o)
		wr(4'h2, 16'h0);
		wr(4'h3, 16'hffff);
		p = $random(seed);
		peer_flags_i <= p;
		lock_status_i <= 1'b1;
		bus_access_i <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		rdc(4'h3, {4'h9, 1'b0, p, 8'h87});
		`CHK("lock", 1'b1, lock_req_o)
		`CHK("peer", 3'h7, peer_flags_o)
		emu_irq_i <= 1'b1;
		repeat (6) @(posedge sys_clk_i);
		`CHK("emu", 1'b1, emu_req_o)
		emu_irq_i <= 1'b0;
		final_report;
	end
endmodule
